// *** core/atfc_pkg.sv ***
// Shared constants and types for the task-file command handler.
package atfc_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_NS = 5;
  localparam int CPU_RST_NS = 100;
  localparam int DIAG_RUN_NS = 2000;
  localparam int HS_WAIT_NS = 10000;
  localparam logic [11:0] CPU_RST_CYC = 12'((CPU_RST_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] DIAG_RUN_CYC = 12'((DIAG_RUN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] HS_WAIT_CYC = 12'(HS_WAIT_NS / CLK_NS);

  // ==========================================================================
  // Task-file register addresses
  localparam logic [2:0] TF_DATA = 3'h0;
  localparam logic [2:0] TF_ERRFEAT = 3'h1;
  localparam logic [2:0] TF_SECCNT = 3'h2;
  localparam logic [2:0] TF_SECNUM = 3'h3;
  localparam logic [2:0] TF_BCLO = 3'h4;
  localparam logic [2:0] TF_BCHI = 3'h5;
  localparam logic [2:0] TF_DRVHD = 3'h6;
  localparam logic [2:0] TF_STATCMD = 3'h7;

  // ==========================================================================
  // Field positions
  localparam int ST_BUSY = 7;
  localparam int ST_DRIVE_READY_FLAG = 6;
  localparam int ST_DSC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int FT_DMA = 0;
  localparam int DRV_SEL_BIT = 4;

  // ==========================================================================
  // Values after reset and completion codes
  localparam logic [7:0] RST_ERR = 8'h01;
  localparam logic [7:0] RST_SECCNT = 8'h01;
  localparam logic [7:0] RST_SECNUM = 8'h01;
  localparam logic [7:0] RST_BCLO = 8'h14;
  localparam logic [7:0] RST_BCHI = 8'heb;
  localparam logic [7:0] RST_DRVHD = 8'h00;
  localparam logic [7:0] RST_XMODE = 8'h00;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_ABORTED = 8'h04;
  localparam logic [7:0] ERR_DIAG_OK = 8'h01;
  localparam logic [7:0] ERR_DIAG_SLV_FAIL = 8'h81;
  localparam logic [7:0] PWR_STANDBY = 8'h00;
  localparam logic [7:0] PWR_IDLE = 8'hff;

  // ==========================================================================
  // Opcodes, feature codes and transfer modes
  localparam logic [7:0] OP_DIAG = 8'h90;
  localparam logic [7:0] OP_IDLE = 8'he1;
  localparam logic [7:0] OP_STBY = 8'he0;
  localparam logic [7:0] OP_CHKPWR = 8'he5;
  localparam logic [7:0] OP_SLEEP = 8'he6;
  localparam logic [7:0] OP_SETF = 8'hef;
  localparam logic [7:0] OP_PACKET = 8'ha0;
  localparam logic [7:0] OP_PIDENT = 8'ha1;
  localparam logic [7:0] OP_SRESET = 8'h08;
  localparam logic [7:0] FEAT_XMODE = 8'h03;
  localparam logic [7:0] FEAT_NOREV = 8'h66;
  localparam logic [7:0] FEAT_REV = 8'hcc;
  localparam logic [7:0] MODE_PIO4_DEF = 8'h00;
  localparam logic [7:0] MODE_PIO2_NORDY = 8'h01;
  localparam logic [7:0] MODE_PIO_LO = 8'h08;
  localparam logic [7:0] MODE_PIO_HI = 8'h0c;
  localparam logic [7:0] MODE_SW_LO = 8'h10;
  localparam logic [7:0] MODE_SW_HI = 8'h12;
  localparam logic [7:0] MODE_MW_LO = 8'h20;
  localparam logic [7:0] MODE_MW_HI = 8'h22;

  // ==========================================================================
  // State types
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_HK = 2'b01,
    S_DIAG = 2'b10,
    S_FW = 2'b11
  } atfc_state_type;

  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_RESET = 2'b01,
    D_RUN = 2'b10,
    D_WAIT = 2'b11
  } atfc_dstate_type;

endpackage

// *** core/atfc_diag_if.sv ***
// Interface between the command handler and its diagnostic sequencer.
`timescale 1ns/1ps
interface atfc_diag_if;
  logic start;
  logic is_slave;
  logic active_in;
  logic passed_in;
  logic done;
  logic slave_ok;
  logic cpu_reset;
  logic active_drive;
  logic passed_drive;
  modport seq (
    input start, is_slave, active_in, passed_in,
    output done, slave_ok, cpu_reset, active_drive, passed_drive
  );
  modport ctl (
    output start, is_slave, active_in, passed_in,
    input done, slave_ok, cpu_reset, active_drive, passed_drive
  );
endinterface

// *** core/atfc_diag_seq.sv ***
// Diagnostic sequencer: processor reset, self test and two-drive handshake.
`timescale 1ns/1ps
module atfc_diag_seq
  import atfc_pkg::*;
(
  input wire logic mclk, // 200 MHz clock
  input wire logic nrst, // Synchronous reset, active low
  atfc_diag_if.seq dg // Handler side
);

  atfc_dstate_type state_r;
  logic [11:0] cnt_r;
  logic seen_r;
  logic done_r;
  logic ok_r;
  logic rst_r;
  logic act_r;
  logic pass_r;

  assign dg.done = done_r;
  assign dg.slave_ok = ok_r;
  assign dg.cpu_reset = rst_r;
  assign dg.active_drive = act_r;
  assign dg.passed_drive = pass_r;

  // ==========================================================================
  // Sequence
  // A master that saw no slave announce itself does not wait for a pass
  // signal, so a lone drive finishes its diagnostics without the timeout.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_r <= D_IDLE;
      cnt_r <= 12'h000;
      seen_r <= 1'b0;
      done_r <= 1'b0;
      ok_r <= 1'b0;
      rst_r <= 1'b0;
      act_r <= 1'b0;
      pass_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      unique case (state_r)
        D_IDLE: begin
          if (dg.start) begin
            state_r <= D_RESET;
            cnt_r <= CPU_RST_CYC - 12'h001;
            rst_r <= 1'b1; // see [R13]
            pass_r <= 1'b0;
            seen_r <= 1'b0;
          end
        end
        D_RESET: begin
          if (cnt_r == 12'h000) begin
            rst_r <= 1'b0;
            state_r <= D_RUN;
            cnt_r <= DIAG_RUN_CYC - 12'h001;
            act_r <= dg.is_slave;
          end else begin
            cnt_r <= cnt_r - 12'h001;
          end
        end
        D_RUN: begin
          if (dg.active_in) begin
            seen_r <= 1'b1;
          end
          if (cnt_r != 12'h000) begin
            cnt_r <= cnt_r - 12'h001;
          end else if (dg.is_slave) begin
            act_r <= 1'b0;
            pass_r <= 1'b1; // see [R13]
            done_r <= 1'b1;
            ok_r <= 1'b1;
            state_r <= D_IDLE;
          end else if (seen_r || dg.active_in) begin
            state_r <= D_WAIT;
            cnt_r <= HS_WAIT_CYC - 12'h001;
          end else begin
            done_r <= 1'b1;
            ok_r <= 1'b1;
            state_r <= D_IDLE;
          end
        end
        D_WAIT: begin
          if (dg.passed_in || cnt_r == 12'h000) begin
            done_r <= 1'b1;
            ok_r <= dg.passed_in; // see [R13]
            state_r <= D_IDLE;
          end else begin
            cnt_r <= cnt_r - 12'h001;
          end
        end
      endcase
    end
  end

endmodule

// *** core/atfc_taskfile.sv ***
// Task-file register block and housekeeping command interpreter.
`timescale 1ns/1ps

// Summary of operation
// [R1] Seek-done flag only when ready for command.
// [R2] Data-request flag whenever data word is ready.
// [R3] Error flag whenever current command had error.
// [R4] Error reason code fills upper four bits.
// [R5] Aborted bit on any abort; media-change reads zero.
// [R6] Partition-end bit set at end of partition.
// [R7] Bad-length bit set on illegal block length.
// [R8] Method bit one selects DMA, zero PIO.
// [R9] Command packet bytes always move by PIO.
// [R10] Host writes method bit before each data command.
// [R11] Completion overwrites feature location with error.
// [R12] Method mismatch leaves busy; host must reset.
// [R13] Diagnostics ignore select, reset, handshake, master interrupts.
// [R14] Idle-immediate records idle, raises interrupt.
// [R15] Standby-immediate records standby, raises interrupt.
// [R16] Check-power returns 00h after standby, else FFh.
// [R17] Sleep acts as idle; commands still accepted.
// [R18] Set-features accepts 03h, 66h, CCh; aborts others.
// [R19] Transfer mode from sector count; unlisted aborted.
// [R20] Mode sets rate only; method bit picks path.
// [R21] Busy set while only device owns registers.
// [R22] Drive-ready only while seek-done is valid.
// [R23] Busy clears with interrupt after status update.
module atfc_taskfile
  import atfc_pkg::*;
(
  input wire logic mclk, // 200 MHz clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic [2:0] hst_addr, // Task-file register address
  input wire logic hst_wr, // Register write strobe
  input wire logic hst_rd, // Register read strobe
  input wire logic [7:0] hst_wdata, // Register write data
  output logic [7:0] hst_rdata, // Register read data
  output logic intrq, // Interrupt request to host
  input wire logic dev_is_slave, // Static jumper: this drive is the slave
  input wire logic diag_passed_line_n_i, // Pass line level from pin
  output logic diag_passed_line_n_o, // Pass line drive value
  output logic diag_passed_line_n_oe, // Pass line output enable
  input wire logic active_present_line_n_i, // Presence line level from pin
  output logic active_present_line_n_o, // Presence line drive value
  output logic active_present_line_n_oe, // Presence line output enable
  output logic fw_cmd_start, // Pulse: command handed to firmware
  output logic [7:0] fw_cmd_op, // Opcode handed to firmware
  input wire logic fw_done, // Pulse: firmware command complete
  input wire logic fw_err, // Firmware command ended in error
  input wire logic [3:0] fw_sense, // Reason code for the error
  input wire logic fw_abort, // Firmware command was aborted
  input wire logic fw_eom, // End of partition detected
  input wire logic fw_ili, // Illegal block length read
  input wire logic fw_data_ready, // A data word is ready to move
  input wire logic fw_packet_phase, // Command packet bytes are moving
  output logic dmarq, // DMA request to host
  output logic dma_mode, // Data phase uses DMA
  output logic [7:0] xfer_mode, // Selected transfer rate mode
  output logic power_standby, // Emulated power state is standby
  output logic cpu_reset // Processor reset pulse from diagnostics
);

  // ==========================================================================
  // Registers
  atfc_state_type state_r;
  logic [7:0] cmd_r;
  logic [7:0] shared_r;
  logic [7:0] seccnt_r;
  logic [7:0] secnum_r;
  logic [7:0] bclo_r;
  logic [7:0] bchi_r;
  logic [7:0] drvhd_r;
  logic [7:0] xmode_r;
  logic [7:0] rdata_r;
  logic busy_r;
  logic drive_ready_flag_r;
  logic dsc_r;
  logic err_r;
  logic standby_r;
  logic intrq_r;
  logic fw_start_r;
  logic [7:0] fw_op_r;

  atfc_diag_if dg_if();

  // ==========================================================================
  // Pin synchronisers
  logic [1:0] pin_in;
  logic [1:0] pin_q;

  assign pin_in = {~active_present_line_n_i, ~diag_passed_line_n_i};

  // A level only counts once the second and third stages agree.
  generate
    for (genvar g = 0; g < 2; g++) begin : g_sync
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic q_r;
      always_ff @(posedge mclk) begin
        if (!nrst) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          q_r <= 1'b0;
        end else begin
          s1_r <= pin_in[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            q_r <= s3_r;
          end
        end
      end
      assign pin_q[g] = q_r;
    end
  endgenerate

  // ==========================================================================
  // Command decode
  logic wr_cmd;
  logic selected;
  logic go;
  logic new_diag;
  logic new_fw;
  logic new_hk;
  logic is_idle;
  logic is_stby;
  logic is_chk;
  logic is_setf;
  logic mode_ok;
  logic setf_ok;
  logic xmode_ok;
  logic hk_ok;

  assign wr_cmd = hst_wr && hst_addr == TF_STATCMD && !busy_r;
  assign selected = drvhd_r[DRV_SEL_BIT] == dev_is_slave;
  assign go = wr_cmd && (selected || hst_wdata == OP_DIAG); // see [R13]
  assign new_diag = hst_wdata == OP_DIAG;
  assign new_fw = hst_wdata == OP_PACKET || hst_wdata == OP_PIDENT
                  || hst_wdata == OP_SRESET;
  assign new_hk = !new_diag && !new_fw;

  assign is_idle = cmd_r == OP_IDLE || cmd_r == OP_SLEEP; // see [R17]
  assign is_stby = cmd_r == OP_STBY;
  assign is_chk = cmd_r == OP_CHKPWR;
  assign is_setf = cmd_r == OP_SETF;
  assign mode_ok = seccnt_r == MODE_PIO4_DEF || seccnt_r == MODE_PIO2_NORDY
                   || (seccnt_r >= MODE_PIO_LO && seccnt_r <= MODE_PIO_HI)
                   || (seccnt_r >= MODE_SW_LO && seccnt_r <= MODE_SW_HI)
                   || (seccnt_r >= MODE_MW_LO && seccnt_r <= MODE_MW_HI); // see [R19]
  assign xmode_ok = shared_r == FEAT_XMODE && mode_ok;
  assign setf_ok = xmode_ok || shared_r == FEAT_NOREV || shared_r == FEAT_REV; // see [R18]
  assign hk_ok = is_idle || is_stby || is_chk || (is_setf && setf_ok);

  // ==========================================================================
  // Completion select
  logic done_evt;
  logic done_aborted_flag;
  logic done_err;
  logic irq_en;
  logic [7:0] done_val;

  // Unknown opcodes, including the plain identify, end here as aborts.
  always_comb begin
    done_evt = 1'b0;
    done_aborted_flag = 1'b0;
    done_err = 1'b0;
    irq_en = 1'b1;
    done_val = ERR_NONE;
    unique case (state_r)
      S_IDLE: begin
        done_evt = 1'b0;
      end
      S_HK: begin
        done_evt = 1'b1;
        done_aborted_flag = !hk_ok;
        done_err = !hk_ok;
        done_val = hk_ok ? ERR_NONE : ERR_ABORTED; // see [R5]
      end
      S_DIAG: begin
        done_evt = dg_if.done;
        irq_en = !dev_is_slave; // see [R13]
        done_val = dg_if.slave_ok ? ERR_DIAG_OK : ERR_DIAG_SLV_FAIL;
      end
      S_FW: begin
        done_evt = fw_done;
        done_aborted_flag = fw_abort;
        done_err = fw_err || fw_abort || fw_eom || fw_ili; // see [R3]
        // Media-change bit is wired to zero.
        done_val = {done_err ? fw_sense : 4'h0, 1'b0, fw_abort,
                    fw_eom, fw_ili}; // see [R4] see [R5] see [R6] see [R7]
      end
    endcase
  end

  // ==========================================================================
  // Sequencer state and status flags
  // Busy only drops through a completion; a method bit that disagrees with
  // the host's transfer stalls the firmware, and only a reset recovers.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_r <= S_IDLE;
      cmd_r <= 8'h00;
      busy_r <= 1'b0;
      drive_ready_flag_r <= 1'b0;
      dsc_r <= 1'b0;
      err_r <= 1'b0;
    end else if (go) begin
      state_r <= new_diag ? S_DIAG : (new_fw ? S_FW : S_HK);
      cmd_r <= hst_wdata;
      busy_r <= 1'b1; // see [R21]
      dsc_r <= 1'b0; // see [R1]
      err_r <= 1'b0;
    end else if (done_evt) begin
      state_r <= S_IDLE;
      busy_r <= 1'b0; // see [R23] see [R12]
      err_r <= done_err; // see [R3]
      dsc_r <= !done_aborted_flag; // see [R1]
      drive_ready_flag_r <= !done_aborted_flag; // see [R22]
    end
  end

  // ==========================================================================
  // Shared feature and error location
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      shared_r <= RST_ERR;
    end else if (done_evt) begin
      shared_r <= done_val; // see [R11]
    end else if (hst_wr && hst_addr == TF_ERRFEAT && !busy_r) begin
      shared_r <= hst_wdata; // see [R10]
    end
  end

  // ==========================================================================
  // Remaining task-file registers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      seccnt_r <= RST_SECCNT;
      secnum_r <= RST_SECNUM;
      bclo_r <= RST_BCLO;
      bchi_r <= RST_BCHI;
      drvhd_r <= RST_DRVHD;
    end else if (state_r == S_HK && is_chk) begin
      seccnt_r <= standby_r ? PWR_STANDBY : PWR_IDLE; // see [R16]
    end else if (hst_wr && !busy_r) begin
      unique case (hst_addr)
        TF_SECCNT: seccnt_r <= hst_wdata;
        TF_SECNUM: secnum_r <= hst_wdata;
        TF_BCLO: bclo_r <= hst_wdata;
        TF_BCHI: bchi_r <= hst_wdata;
        TF_DRVHD: drvhd_r <= hst_wdata;
        TF_DATA, TF_ERRFEAT, TF_STATCMD: begin
          drvhd_r <= drvhd_r;
        end
      endcase
    end
  end

  // ==========================================================================
  // Emulated power state and transfer mode
  // Every completion rewrites the power flag, so only a check that directly
  // follows a standby reports standby.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      standby_r <= 1'b0;
      xmode_r <= RST_XMODE;
    end else if (done_evt) begin
      standby_r <= is_stby && state_r == S_HK; // see [R14] see [R15] see [R16]
      if (state_r == S_HK && is_setf && xmode_ok) begin
        xmode_r <= seccnt_r; // see [R19] see [R20]
      end
    end
  end

  // ==========================================================================
  // Interrupt request
  // A completion in the cycle of a status read keeps the request set.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      intrq_r <= 1'b0;
    end else if (done_evt && irq_en) begin
      intrq_r <= 1'b1; // see [R14] see [R15] see [R23]
    end else if ((hst_rd && hst_addr == TF_STATCMD) || go) begin
      intrq_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Host read path
  logic busy_flag;
  logic drive_ready_flag;
  logic seek_done_flag;
  logic data_request_flag;
  logic [7:0] status_w;

  // Busy is lowered while a data word waits so the host may move it.
  assign data_request_flag = fw_data_ready && state_r == S_FW; // see [R2]
  assign busy_flag = busy_r && !data_request_flag; // see [R21]
  assign seek_done_flag = dsc_r && !busy_r; // see [R1]
  assign drive_ready_flag = drive_ready_flag_r && seek_done_flag; // see [R22]
  always_comb begin
    status_w = 8'h00;
    status_w[ST_BUSY] = busy_flag;
    status_w[ST_DRIVE_READY_FLAG] = drive_ready_flag;
    status_w[ST_DSC] = seek_done_flag;
    status_w[ST_DRQ] = data_request_flag;
    status_w[ST_ERR] = err_r;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdata_r <= 8'h00;
    end else if (hst_rd) begin
      unique case (hst_addr)
        TF_DATA: rdata_r <= 8'h00;
        TF_ERRFEAT: rdata_r <= shared_r;
        TF_SECCNT: rdata_r <= seccnt_r;
        TF_SECNUM: rdata_r <= secnum_r;
        TF_BCLO: rdata_r <= bclo_r;
        TF_BCHI: rdata_r <= bchi_r;
        TF_DRVHD: rdata_r <= drvhd_r;
        TF_STATCMD: rdata_r <= status_w;
      endcase
    end
  end

  // ==========================================================================
  // Firmware hand-off
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      fw_start_r <= 1'b0;
      fw_op_r <= 8'h00;
    end else begin
      fw_start_r <= go && new_fw;
      if (go) begin
        fw_op_r <= hst_wdata;
      end
    end
  end

  // ==========================================================================
  // Diagnostic sequencer
  assign dg_if.start = go && new_diag;
  assign dg_if.is_slave = dev_is_slave;
  assign dg_if.active_in = pin_q[1];
  assign dg_if.passed_in = pin_q[0];

  atfc_diag_seq u_diag (
    .mclk(mclk),
    .nrst(nrst),
    .dg(dg_if.seq)
  );

  // ==========================================================================
  // Outputs
  assign hst_rdata = rdata_r;
  assign intrq = intrq_r;
  assign diag_passed_line_n_o = 1'b0;
  assign diag_passed_line_n_oe = dg_if.passed_drive;
  assign active_present_line_n_o = 1'b0;
  assign active_present_line_n_oe = dg_if.active_drive;
  assign fw_cmd_start = fw_start_r;
  assign fw_cmd_op = fw_op_r;
  assign dma_mode = shared_r[FT_DMA]; // see [R8] see [R20]
  assign dmarq = data_request_flag && dma_mode && !fw_packet_phase; // see [R8] see [R9]
  assign xfer_mode = xmode_r;
  assign power_standby = standby_r;
  assign cpu_reset = dg_if.cpu_reset;

endmodule

// *** verification/atfc_taskfile_properties.sv ***
// Port checker for the task-file command handler.
`timescale 1ns/1ps
module atfc_taskfile_properties
  import atfc_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic nrst, // Reset
  input wire logic [2:0] hst_addr, // Address
  input wire logic hst_wr, // Write
  input wire logic [7:0] hst_wdata, // Data
  input wire logic intrq, // Interrupt
  input wire logic dev_is_slave, // Strap
  input wire logic diag_passed_line_n_o, // Pass value
  input wire logic diag_passed_line_n_oe, // Pass enable
  input wire logic fw_data_ready, // Word ready
  input wire logic fw_packet_phase, // Packet bytes
  input wire logic dmarq, // DMA request
  input wire logic dma_mode, // Method bit
  input wire logic [7:0] xfer_mode, // Rate mode
  input wire logic power_standby, // Standby
  input wire logic cpu_reset // Reset pulse
);
  // ==========
  // Properties
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  wire logic cmd_wr = hst_wr && hst_addr == TF_STATCMD;
  wire logic setf_wr = cmd_wr && hst_wdata == OP_SETF;
  wire logic dma_cause = fw_data_ready && dma_mode && !fw_packet_phase;
  sequence s_cmd(logic [7:0] op);
    cmd_wr && hst_wdata == op;
  endsequence
  AST_IDLE_INT: assert property (s_cmd(OP_IDLE) |-> ##2 intrq && !power_standby)
    else $error("idle command result wrong");
  AST_STBY_REC: assert property (s_cmd(OP_STBY) |-> ##2 intrq && power_standby)
    else $error("standby command result wrong");
  AST_SLEEP_IDLE: assert property (s_cmd(OP_SLEEP) |-> ##2 intrq && !power_standby)
    else $error("sleep command result wrong");
  AST_DMA_PATH: assert property (dmarq |-> dma_cause)
    else $error("DMA request without cause");
  AST_MODE_SRC: assert property ($changed(xfer_mode) |-> $past(setf_wr, 2))
    else $error("mode changed without set features");
  AST_DIAG_RST: assert property (s_cmd(OP_DIAG) |=> cpu_reset [*8])
    else $error("diagnostics gave no processor reset");
  AST_MASTER_PASS: assert property (!dev_is_slave |-> !diag_passed_line_n_oe)
    else $error("master drives pass line");
  AST_PASS_LOW: assert property (diag_passed_line_n_oe |-> !diag_passed_line_n_o)
    else $error("pass line driven high");
endmodule
bind atfc_taskfile atfc_taskfile_properties atfc_taskfile_properties_i (.*);

// *** verification/atfc_host_model.sv ***
// Host adapter model issuing task-file register cycles.
`timescale 1ns/1ps
module atfc_host_model (
  input wire logic mclk, // Clock
  output logic [2:0] addr, // Address
  output logic wr, // Write strobe
  output logic rd, // Read strobe
  output logic [7:0] wdata // Write data
);
  // ==========
  // Bus cycles, changed only at the falling edge
  initial begin
    addr = 3'h0;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
  end
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge mclk);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a);
    @(negedge mclk);
    addr = a;
    rd = 1'b1;
    @(negedge mclk);
    rd = 1'b0;
  endtask
endmodule

// *** verification/atfc_taskfile_bench.sv ***
// Self-checking bench for the task-file command handler.
`timescale 1ns/1ps
module atfc_taskfile_bench;
  import atfc_pkg::*;
  logic mclk, nrst, fw_done, fw_err, fw_abort, fw_eom, fw_ili, fw_data_ready, fw_packet_phase;
  logic [3:0] fw_sense;
  logic [2:0] hst_addr;
  logic [7:0] hst_wdata, hst_rdata, fw_cmd_op, xfer_mode;
  logic hst_wr, hst_rd, intrq, dmarq, dma_mode, power_standby, cpu_reset, fw_cmd_start;
  logic pass_o, pass_oe, pres_o, pres_oe;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  // Feature, sector count, expected error, expected mode.
  logic [31:0] sf [9] = '{32'h03220022, 32'h03050422, 32'h66000022, 32'hcc000022,
    32'h55000422, 32'h03010001, 32'h03130401, 32'h03100010, 32'h030d0410};
  // Open-drain pins with pull-ups: released means high.
  wire logic pass_lvl = pass_oe ? pass_o : 1'b1;
  wire logic pres_lvl = pres_oe ? pres_o : 1'b1;
  atfc_host_model atfc_host_model_i (.mclk, .addr(hst_addr), .wr(hst_wr), .rd(hst_rd),
    .wdata(hst_wdata));
  atfc_taskfile atfc_taskfile_i (.mclk, .nrst, .hst_addr, .hst_wr, .hst_rd, .hst_wdata,
    .hst_rdata, .intrq, .dev_is_slave(1'b0), .diag_passed_line_n_i(pass_lvl),
    .diag_passed_line_n_o(pass_o), .diag_passed_line_n_oe(pass_oe),
    .active_present_line_n_i(pres_lvl), .active_present_line_n_o(pres_o),
    .active_present_line_n_oe(pres_oe), .fw_cmd_start, .fw_cmd_op, .fw_done, .fw_err,
    .fw_sense, .fw_abort, .fw_eom, .fw_ili, .fw_data_ready, .fw_packet_phase, .dmarq,
    .dma_mode, .xfer_mode, .power_standby, .cpu_reset);
  // ==========
  // Clock, timeout and checks
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      summarize();
    end
  end
  task automatic summarize();
    if (err_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic chk_rd(input logic [2:0] a, input logic [7:0] exp);
    atfc_host_model_i.rd_reg(a);
    cmp8(hst_rdata, exp);
  endtask
  task automatic cmd(input logic [7:0] op);
    int n;
    n = 0;
    atfc_host_model_i.wr_reg(TF_STATCMD, op);
    cmp1(intrq, 1'b0);
    @(negedge mclk);
    while (intrq !== 1'b1 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    cmp1(intrq, 1'b1);
  endtask
  // ==========
  // Test sequence
  initial begin
    {nrst, fw_done, fw_err, fw_abort, fw_eom, fw_ili, fw_data_ready, fw_packet_phase} = '0;
    fw_sense = 4'h0;
    repeat (20) @(negedge mclk);
    nrst = 1'b1;
    chk_rd(TF_STATCMD, 8'h00);
    chk_rd(TF_ERRFEAT, RST_ERR);
    chk_rd(TF_BCHI, RST_BCHI);
    cmd(OP_IDLE);
    chk_rd(TF_STATCMD, 8'h50);
    chk_rd(TF_ERRFEAT, ERR_NONE);
    cmd(OP_STBY);
    cmd(OP_CHKPWR);
    chk_rd(TF_SECCNT, PWR_STANDBY);
    cmd(OP_SLEEP);
    cmd(OP_CHKPWR);
    chk_rd(TF_SECCNT, PWR_IDLE);
    foreach (sf[i]) begin
      atfc_host_model_i.wr_reg(TF_SECCNT, sf[i][23:16]);
      atfc_host_model_i.wr_reg(TF_ERRFEAT, sf[i][31:24]);
      cmd(OP_SETF);
      chk_rd(TF_ERRFEAT, sf[i][15:8]);
      chk_rd(TF_STATCMD, (sf[i][15:8] == 8'h00) ? 8'h50 : 8'h01);
      cmp8(xfer_mode, sf[i][7:0]);
    end
    cmd(8'hec);
    chk_rd(TF_ERRFEAT, ERR_ABORTED);
    for (int m = 1; m >= 0; m--) begin
      atfc_host_model_i.wr_reg(TF_ERRFEAT, 8'(m));
      atfc_host_model_i.wr_reg(TF_STATCMD, OP_PACKET);
      cmp1(fw_cmd_start, 1'b1);
      @(negedge mclk);
      cmp1(fw_cmd_start, 1'b0);
      fw_packet_phase = 1'b1;
      fw_data_ready = 1'b1;
      @(negedge mclk);
      cmp1(dmarq, 1'b0);
      cmp8(fw_cmd_op, OP_PACKET);
      fw_packet_phase = 1'b0;
      @(negedge mclk);
      cmp1(dmarq, m[0]);
      cmp1(dma_mode, m[0]);
      chk_rd(TF_STATCMD, 8'h08);
      {fw_data_ready, fw_err, fw_eom, fw_ili, fw_done, fw_sense} = {5'h0f, 4'h5};
      @(negedge mclk);
      fw_done = 1'b0;
      repeat (2) @(negedge mclk);
      cmp1(intrq, 1'b1);
      chk_rd(TF_ERRFEAT, 8'h53);
      chk_rd(TF_STATCMD, 8'h51);
    end
    atfc_host_model_i.wr_reg(TF_DRVHD, 8'h10);
    cmd(OP_DIAG);
    chk_rd(TF_ERRFEAT, ERR_DIAG_OK);
    cmp1(pres_oe, 1'b0);
    // A packet command that never completes must hold busy until a reset.
    atfc_host_model_i.wr_reg(TF_DRVHD, 8'h00);
    atfc_host_model_i.wr_reg(TF_STATCMD, OP_PACKET);
    repeat (50) @(negedge mclk);
    chk_rd(TF_STATCMD, 8'h80);
    nrst = 1'b0;
    repeat (4) @(negedge mclk);
    nrst = 1'b1;
    chk_rd(TF_STATCMD, 8'h00);
    cmp8(xfer_mode, RST_XMODE);
    cmp1(intrq, 1'b0);
    summarize();
  end
endmodule
